//--- verilog/fpc_pkg.sv
// package: formats, biases, trap codes, operations and state type
`default_nettype none
package fpc_pkg;

  // operand field layout
  localparam int          SGL_WIDTH     = 32;
  localparam int          DBL_WIDTH     = 64;
  localparam int          SGL_EXP_W     = 8;
  localparam int          SGL_FRAC_W    = 23;
  localparam int          DBL_EXP_W     = 11;
  localparam int          DBL_FRAC_W    = 52;
  localparam int          SGL_SIGN_POS  = 31;
  localparam int          DBL_SIGN_POS  = 63;
  localparam int          FRAC_ALIGN    = 29;  // single fraction moved up
  localparam logic [11:0] SGL_BIAS      = 12'h07f;
  localparam logic [11:0] DBL_BIAS      = 12'h3ff;
  localparam logic [10:0] SGL_EXP_MAX   = 11'h0ff;
  localparam logic [10:0] DBL_EXP_MAX   = 11'h7ff;
  localparam logic [63:0] SGL_SIGN_MASK = 64'h0000_0000_8000_0000;
  localparam logic [63:0] DBL_SIGN_MASK = 64'h8000_0000_0000_0000;

  // integer conversion constants
  localparam logic [11:0] INT_TOP_BIT   = 12'h01f;
  localparam logic [11:0] SIGNIF_TOP    = 12'h034;
  localparam logic [5:0]  INT_BITS_B    = 6'h08;
  localparam logic [5:0]  INT_BITS_W    = 6'h10;
  localparam logic [5:0]  INT_BITS_D    = 6'h20;

  // trap type codes
  localparam logic [2:0]  TRAP_NONE      = 3'h0;
  localparam logic [2:0]  TRAP_UNDERFLOW = 3'h1;
  localparam logic [2:0]  TRAP_OVERFLOW  = 3'h2;
  localparam logic [2:0]  TRAP_ILLEGAL   = 3'h4;
  localparam logic [2:0]  TRAP_INVALID   = 3'h5;
  localparam logic [2:0]  TRAP_INEXACT   = 3'h6;

  typedef enum logic [2:0] {
    FPC_OP_MOV,
    FPC_OP_NEG,
    FPC_OP_CVTI,
    FPC_OP_TRUNC,
    FPC_OP_SCALE
  } fpc_op_t;

  typedef enum logic [1:0] {
    FPC_INT_BYTE,
    FPC_INT_WORD,
    FPC_INT_DWORD
  } fpc_int_len_t;

  typedef struct packed {
    logic        resValid;
    logic        resWrite;
    logic [63:0] resWord;
    logic        resDouble;
    logic        resFloat;
    logic        fromMove;
    logic        trapReq;
    logic [2:0]  trapTypeCode;
    logic        clsZero;
    logic        clsReserved;
    logic        clsNormal;
    logic        clsSign;
    logic [11:0] clsTrueExp;
    logic [52:0] clsSignif;
  } fpc_state_t;

endpackage
`default_nettype wire

//--- verilog/fpc_unpack.sv
// combinational field split and classification of one float operand
`default_nettype none
module fpc_unpack (
  input  wire logic        opIsDouble,
  input  wire logic [63:0] opWord,
  output logic             fldSign,
  output logic      [10:0] fldExp,
  output logic      [51:0] fldFrac,
  output logic      [11:0] trueExp,
  output logic      [52:0] signif,
  output logic             isZero,
  output logic             isReserved,
  output logic             isNormal
);

  logic        expAllOnes;
  logic        expAllZero;
  logic        fracZero;

  // sign on top, then exponent, then fraction
  always_comb begin
    if (opIsDouble) begin
      fldSign = opWord[fpc_pkg::DBL_SIGN_POS];
      fldExp  = opWord[62:52];
      fldFrac = opWord[51:0];
    end else begin
      fldSign = opWord[fpc_pkg::SGL_SIGN_POS];
      fldExp  = {3'h0, opWord[30:23]};
      fldFrac = {opWord[22:0], 29'h0};  // aligned to the double frame
    end
  end

  // classification has no clock so the trap is known before any write
  always_comb begin
    expAllOnes = fldExp == (opIsDouble ? fpc_pkg::DBL_EXP_MAX
                                       : fpc_pkg::SGL_EXP_MAX);
    expAllZero = fldExp == 11'h000;
    fracZero   = fldFrac == 52'h0;
    isZero     = expAllZero && fracZero;
    isReserved = expAllOnes || (expAllZero && !fracZero);
    isNormal   = !expAllOnes && !expAllZero;
    trueExp    = {1'b0, fldExp} - (opIsDouble ? fpc_pkg::DBL_BIAS
                                              : fpc_pkg::SGL_BIAS);
    signif     = {isNormal, fldFrac};  // hidden one left of the point
  end

endmodule
`default_nettype wire

//--- verilog/fpc_operand_classifier.sv
// float operand classifier, move/negate/convert/scale datapath
//
// Functional notes
// - only 32-bit single and 64-bit double float widths exist.
// - precision select sizes every float operand of the instruction.
// - normalized fraction sits right of the point behind a hidden one.
// - true exponent is biased field minus 127 or 1023.
// - exponent all ones is always a reserved operand.
// - exponent zero: zero if fraction zero, else reserved denormal.
// - sign bit 0 means positive, 1 negative, sign-magnitude values.
// - negation flips only the sign bit.
// - normal value is sign, two to true exponent, one plus fraction.
// - positive and negative zero are both recognised.
// - reserved operand traps as invalid on negate, truncate and scale; a plain move passes it.
// - invalid operation records trap type code 101.
// - infinity, NaN and denormals are never produced as results except by a plain move.
// - underflow with trap disabled delivers exactly zero.
// - integers are two's complement of 8, 16 or 32 bits.
// - no memory access here; the host moves all operands.
`default_nettype none
module fpc_operand_classifier (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        opValid,
  input  wire logic        opIsDouble,
  input  wire logic [2:0]  opCode,
  input  wire logic [1:0]  intLen,
  input  wire logic [63:0] opA,
  input  wire logic [31:0] scaleCnt,
  input  wire logic        underflowTrapEnable,
  output logic             resValid,
  output logic             resWrite,
  output logic      [63:0] resWord,
  output logic             trapReq,
  output logic      [2:0]  trapTypeCode,
  output logic             clsZero,
  output logic             clsReserved,
  output logic             clsNormal,
  output logic             clsSign,
  output logic      [11:0] clsTrueExp,
  output logic      [52:0] clsSignif
);

  fpc_pkg::fpc_state_t state_ff;
  fpc_pkg::fpc_state_t nxt_state;

  logic        fldSign;
  logic [10:0] fldExp;
  logic [51:0] fldFrac;
  logic [11:0] trueExp;
  logic [52:0] signif;
  logic        isZero;
  logic        isReserved;
  logic        isNormal;

  // operand fields come straight from the bus, no register in between
  fpc_unpack fpc_unpack_inst (
    .opIsDouble (opIsDouble),
    .opWord     (opA),
    .fldSign    (fldSign),
    .fldExp     (fldExp),
    .fldFrac    (fldFrac),
    .trueExp    (trueExp),
    .signif     (signif),
    .isZero     (isZero),
    .isReserved (isReserved),
    .isNormal   (isNormal)
  );

  // keeps only the bits of the selected precision
  function automatic logic [63:0] fitWidth(input logic dbl,
                                           input logic [63:0] w);
    return dbl ? w : {32'h0, w[31:0]};
  endfunction

  // assembles sign, biased exponent and aligned fraction
  function automatic logic [63:0] packFloat(input logic dbl,
                                            input logic s,
                                            input logic [10:0] e,
                                            input logic [51:0] f);
    return dbl ? {s, e, f} : {32'h0, s, e[7:0], f[51:29]};
  endfunction

  function automatic logic [31:0] signExt(input logic [1:0] len,
                                          input logic [31:0] v);
    case (len)
      2'h0:    return {{24{v[7]}}, v[7:0]};
      2'h1:    return {{16{v[15]}}, v[15:0]};
      default: return v;
    endcase
  endfunction

  function automatic logic [5:0] intBits(input logic [1:0] len);
    case (len)
      2'h0:    return fpc_pkg::INT_BITS_B;
      2'h1:    return fpc_pkg::INT_BITS_W;
      default: return fpc_pkg::INT_BITS_D;
    endcase
  endfunction

  // leading zero count, 32 for an all-zero word
  function automatic logic [5:0] lzc32(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h20;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) n = 6'(31 - i);
    end
    return n;
  endfunction

  logic [31:0]        intVal;
  logic [31:0]        intMag;
  logic [5:0]         lz;
  logic [31:0]        intNorm;
  logic [11:0]        cvtExp;
  logic [5:0]         truncShamt;
  logic [63:0]        signif64;
  logic [63:0]        truncMag;
  logic               truncLost;
  logic [32:0]        intLim;
  logic [31:0]        truncInt;
  logic signed [33:0] scaledExp;
  logic [10:0]        expMax;
  logic [63:0]        signMask;

  // shared arithmetic for conversions and scaling
  always_comb begin
    intVal     = signExt(intLen, opA[31:0]);
    intMag     = intVal[31] ? 32'(-intVal) : intVal;
    lz         = lzc32(intMag);
    intNorm    = intMag << lz;
    cvtExp     = fpc_pkg::INT_TOP_BIT - {6'h0, lz}
               + (opIsDouble ? fpc_pkg::DBL_BIAS : fpc_pkg::SGL_BIAS);
    truncShamt = 6'(fpc_pkg::SIGNIF_TOP - trueExp);
    signif64   = {11'h0, signif};
    truncMag   = signif64 >> truncShamt;
    truncLost  = (signif64 & ((64'h1 << truncShamt) - 64'h1)) != 64'h0;
    intLim     = (33'h1 << (intBits(intLen) - 6'h01))
               - {32'h0, !fldSign};  // negative side reaches one further
    truncInt   = fldSign ? 32'(-truncMag[31:0]) : truncMag[31:0];
    scaledExp  = $signed({23'h0, fldExp})
               + $signed({{2{scaleCnt[31]}}, scaleCnt});
    expMax     = opIsDouble ? fpc_pkg::DBL_EXP_MAX : fpc_pkg::SGL_EXP_MAX;
    signMask   = opIsDouble ? fpc_pkg::DBL_SIGN_MASK
                            : fpc_pkg::SGL_SIGN_MASK;
  end

  // next state: one operation per valid cycle, answer one cycle later
  always_comb begin
    nxt_state          = state_ff;
    nxt_state.resValid = 1'b0;
    nxt_state.resWrite = 1'b0;
    nxt_state.trapReq  = 1'b0;
    if (opValid) begin
      nxt_state.resValid     = 1'b1;
      nxt_state.resDouble    = opIsDouble;
      nxt_state.resFloat     = 1'b1;
      nxt_state.fromMove     = 1'b0;
      nxt_state.trapTypeCode = fpc_pkg::TRAP_NONE;
      nxt_state.clsZero      = isZero;
      nxt_state.clsReserved  = isReserved;
      nxt_state.clsNormal    = isNormal;
      nxt_state.clsSign      = fldSign;
      nxt_state.clsTrueExp   = trueExp;
      nxt_state.clsSignif    = signif;
      unique case (fpc_pkg::fpc_op_t'(opCode))
        fpc_pkg::FPC_OP_MOV: begin
          // a plain move carries reserved encodings through untouched
          nxt_state.resWrite = 1'b1;
          nxt_state.fromMove = 1'b1;
          nxt_state.resWord  = fitWidth(opIsDouble, opA);
        end
        fpc_pkg::FPC_OP_NEG: begin
          if (isReserved) begin
            nxt_state.trapReq      = 1'b1;
            nxt_state.trapTypeCode = fpc_pkg::TRAP_INVALID;
          end else begin
            nxt_state.resWrite = 1'b1;
            nxt_state.resWord  = fitWidth(opIsDouble, opA) ^ signMask;
          end
        end
        fpc_pkg::FPC_OP_CVTI: begin
          nxt_state.resWrite = 1'b1;
          if (intMag == 32'h0) begin
            nxt_state.resWord = 64'h0;
          end else begin
            nxt_state.resWord = packFloat(opIsDouble, intVal[31],
                                          cvtExp[10:0],
                                          {intNorm[30:0], 21'h0});
            // single keeps 24 bits; the rest is cut toward zero
            if (!opIsDouble && intNorm[7:0] != 8'h00) begin
              nxt_state.trapTypeCode = fpc_pkg::TRAP_INEXACT;
            end
          end
        end
        fpc_pkg::FPC_OP_TRUNC: begin
          nxt_state.resFloat = 1'b0;
          if (isReserved) begin
            nxt_state.trapReq      = 1'b1;
            nxt_state.trapTypeCode = fpc_pkg::TRAP_INVALID;
          end else if (isZero || trueExp[11]) begin
            nxt_state.resWrite = 1'b1;
            nxt_state.resWord  = 64'h0;
            if (!isZero) nxt_state.trapTypeCode = fpc_pkg::TRAP_INEXACT;
          end else if (trueExp > fpc_pkg::INT_TOP_BIT ||
                       {1'b0, truncMag[31:0]} > intLim) begin
            nxt_state.trapReq      = 1'b1;
            nxt_state.trapTypeCode = fpc_pkg::TRAP_OVERFLOW;
          end else begin
            nxt_state.resWrite = 1'b1;
            nxt_state.resWord  = {32'h0, truncInt};
            if (truncLost) nxt_state.trapTypeCode = fpc_pkg::TRAP_INEXACT;
          end
        end
        fpc_pkg::FPC_OP_SCALE: begin
          if (isReserved) begin
            nxt_state.trapReq      = 1'b1;
            nxt_state.trapTypeCode = fpc_pkg::TRAP_INVALID;
          end else if (isZero) begin
            nxt_state.resWrite = 1'b1;
            nxt_state.resWord  = fitWidth(opIsDouble, opA);
          end else if (scaledExp >= $signed({23'h0, expMax})) begin
            // never hand out infinity: trap and write nothing
            nxt_state.trapReq      = 1'b1;
            nxt_state.trapTypeCode = fpc_pkg::TRAP_OVERFLOW;
          end else if (scaledExp <= 34'sh0) begin
            // underflow is always reported, trapped only when enabled
            nxt_state.trapTypeCode = fpc_pkg::TRAP_UNDERFLOW;
            nxt_state.trapReq      = underflowTrapEnable;
            nxt_state.resWrite     = !underflowTrapEnable;
            nxt_state.resWord      = 64'h0;
          end else begin
            nxt_state.resWrite = 1'b1;
            nxt_state.resWord  = packFloat(opIsDouble, fldSign,
                                           scaledExp[10:0], fldFrac);
          end
        end
        default: begin
          nxt_state.trapReq      = 1'b1;
          nxt_state.trapTypeCode = fpc_pkg::TRAP_ILLEGAL;
        end
      endcase
    end
  end

  // the single state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  assign resValid     = state_ff.resValid;
  assign resWrite     = state_ff.resWrite;
  assign resWord      = state_ff.resWord;
  assign trapReq      = state_ff.trapReq;
  assign trapTypeCode = state_ff.trapTypeCode;
  assign clsZero      = state_ff.clsZero;
  assign clsReserved  = state_ff.clsReserved;
  assign clsNormal    = state_ff.clsNormal;
  assign clsSign      = state_ff.clsSign;
  assign clsTrueExp   = state_ff.clsTrueExp;
  assign clsSignif    = state_ff.clsSignif;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // assertions
  property p_mov_pass;
    opValid && opCode == 3'h0 |=>
      resWrite && resWord == fitWidth($past(opIsDouble), $past(opA));
  endproperty
  a_mov_pass: assert property (p_mov_pass)
    else $error("move did not pass the operand through");

  property p_reserved_trap;
    opValid && isReserved
      && (opCode == 3'h1 || opCode == 3'h3 || opCode == 3'h4) |=>
      trapReq && !resWrite && trapTypeCode == 3'h5;
  endproperty
  a_reserved_trap: assert property (p_reserved_trap)
    else $error("reserved operand did not raise invalid trap");

  property p_neg_sign;
    opValid && opCode == 3'h1 && !isReserved |=>
      resWrite && (resWord ^ $past(fitWidth(opIsDouble, opA)))
                  == $past(signMask);
  endproperty
  a_neg_sign: assert property (p_neg_sign)
    else $error("negate changed more than the sign bit");

  property p_no_reserved_out;
    resWrite && !state_ff.fromMove && state_ff.resFloat |->
      (state_ff.resDouble
        ? (resWord[62:52] != 11'h7ff
           && (resWord[62:52] != 11'h0 || resWord[51:0] == 52'h0))
        : (resWord[30:23] != 8'hff
           && (resWord[30:23] != 8'h0 || resWord[22:0] == 23'h0)));
  endproperty
  a_no_reserved_out: assert property (p_no_reserved_out)
    else $error("reserved encoding produced as a result");

  property p_underflow_flush;
    opValid && opCode == 3'h4 && isNormal && scaledExp <= 34'sh0
      && !underflowTrapEnable |=>
      resWrite && !trapReq && resWord == 64'h0 && trapTypeCode == 3'h1;
  endproperty
  a_underflow_flush: assert property (p_underflow_flush)
    else $error("underflow with trap off did not give zero");

  property p_zero_class;
    opValid && fldExp == 11'h0 |=>
      clsZero == ($past(fldFrac) == 52'h0) && clsReserved == !clsZero;
  endproperty
  a_zero_class: assert property (p_zero_class)
    else $error("zero exponent misclassified");

  property p_all_ones;
    opValid && fldExp == expMax |=> clsReserved && !clsNormal;
  endproperty
  a_all_ones: assert property (p_all_ones)
    else $error("all-ones exponent not reserved");

  property p_bias;
    resValid && clsNormal |->
      clsTrueExp == {1'b0, $past(fldExp)}
                    - ($past(opIsDouble) ? 12'h3ff : 12'h07f)
      && clsSignif[52];
  endproperty
  a_bias: assert property (p_bias)
    else $error("true exponent or hidden bit wrong");

  property p_single_width;
    resWrite && !state_ff.resDouble |-> resWord[63:32] == 32'h0;
  endproperty
  a_single_width: assert property (p_single_width)
    else $error("single result spills above 32 bits");

  c_move_reserved: cover property (opValid && opCode == 3'h0 && isReserved);
  c_underflow: cover property (resValid && trapTypeCode == 3'h1);
  c_cvt_int: cover property (opValid && opCode == 3'h2 ##1 resWrite);
  c_trunc_ovf: cover property (resValid && trapTypeCode == 3'h2);

endmodule
`default_nettype wire

//--- test/fpc_host_model.sv
// host model: gathers operand bytes and issues one request per go
`default_nettype none
module fpc_host_model (
  input  wire logic        clk_sys,
  input  wire logic        reqGo,
  input  wire logic        reqImm,
  input  wire logic        reqDouble,
  input  wire logic [2:0]  reqCode,
  input  wire logic [1:0]  reqLen,
  input  wire logic [31:0] reqScale,
  input  wire logic        reqUte,
  input  wire logic [63:0] reqBytes,
  output logic             opValid,
  output logic             opIsDouble,
  output logic      [2:0]  opCode,
  output logic      [1:0]  intLen,
  output logic      [63:0] opA,
  output logic      [31:0] scaleCnt,
  output logic             underflowTrapEnable
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [63:0] gathered;
  int          nBytes;

  // byte i sits at address i; immediates come highest byte first
  always_comb begin
    gathered = 64'h0;
    nBytes = reqDouble ? 8 : 4;
    for (int i = 0; i < 8; i++) begin
      if (i < nBytes) begin
        if (reqImm) begin
          gathered[8*(nBytes-1-i) +: 8] = reqBytes[8*i +: 8];
        end else begin
          gathered[8*i +: 8] = reqBytes[8*i +: 8];
        end
      end
    end
  end

  // launch on the falling edge; a released operand bus shows noise
  always @(negedge clk_sys) begin
    opValid <= reqGo;
    if (reqGo) begin
      opA <= gathered;
      opIsDouble <= reqDouble;
      opCode <= reqCode;
      intLen <= reqLen;
      scaleCnt <= reqScale;
      underflowTrapEnable <= reqUte;
    end else begin
      opA <= ~opA;  // no stale value may pass for a real operand
    end
  end
endmodule
`default_nettype wire

//--- test/fp_operand_format_classifier_tb.sv
// testbench for the float operand classifier and its datapath
`default_nettype none
module fp_operand_format_classifier_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        rst;
  logic        reqGo, reqImm, reqDouble, reqUte;
  logic [2:0]  reqCode;
  logic [1:0]  reqLen;
  logic [31:0] reqScale;
  logic [63:0] reqBytes;
  logic        opValid, opIsDouble, underflowTrapEnable;
  logic [2:0]  opCode;
  logic [1:0]  intLen;
  logic [63:0] opA;
  logic [31:0] scaleCnt;
  logic        resValid, resWrite, trapReq;
  logic [63:0] resWord;
  logic [2:0]  trapTypeCode;
  logic        clsZero, clsReserved, clsNormal, clsSign;
  logic [11:0] clsTrueExp;
  logic [52:0] clsSignif;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;

  always #4 clk_sys = ~clk_sys;

  fpc_host_model fpc_host_model_inst (
    .clk_sys(clk_sys), .reqGo(reqGo), .reqImm(reqImm),
    .reqDouble(reqDouble), .reqCode(reqCode), .reqLen(reqLen),
    .reqScale(reqScale), .reqUte(reqUte), .reqBytes(reqBytes),
    .opValid(opValid), .opIsDouble(opIsDouble), .opCode(opCode),
    .intLen(intLen), .opA(opA), .scaleCnt(scaleCnt),
    .underflowTrapEnable(underflowTrapEnable));

  fpc_operand_classifier fpc_operand_classifier_inst (
    .clk_sys(clk_sys), .rst(rst), .opValid(opValid),
    .opIsDouble(opIsDouble), .opCode(opCode), .intLen(intLen),
    .opA(opA), .scaleCnt(scaleCnt),
    .underflowTrapEnable(underflowTrapEnable),
    .resValid(resValid), .resWrite(resWrite), .resWord(resWord),
    .trapReq(trapReq), .trapTypeCode(trapTypeCode),
    .clsZero(clsZero), .clsReserved(clsReserved),
    .clsNormal(clsNormal), .clsSign(clsSign),
    .clsTrueExp(clsTrueExp), .clsSignif(clsSignif));

  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] expv);
    compares++;
    if (seen !== expv) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  // spread a word over bytes the way the host stores it
  function automatic logic [63:0] toBytes(input logic [63:0] w,
                                          input logic dbl, input logic imm);
    logic [63:0] b;
    int          n;
    b = 64'h0;
    n = dbl ? 8 : 4;
    for (int i = 0; i < n; i++) begin
      b[8*i +: 8] = imm ? w[8*(n-1-i) +: 8] : w[8*i +: 8];
    end
    return b;
  endfunction

  // one op; e is {write, trap, code}; result seen one cycle on
  task automatic doOp(input logic [2:0] code, input logic dbl,
                      input logic [1:0] len, input logic [31:0] sc,
                      input logic [63:0] w, input logic [4:0] e,
                      input logic [63:0] res);
    reqCode = code;
    reqDouble = dbl;
    reqLen = len;
    reqScale = sc;
    reqBytes = toBytes(w, dbl, reqImm);
    reqGo = 1'b1;
    @(negedge clk_sys);
    @(posedge clk_sys);
    #1;
    chk(64'({resValid, resWrite, trapReq, trapTypeCode}), 64'({1'b1, e}));
    if (e[4]) begin
      chk(resWord, res);
    end
  endtask

  // classification flags {zero, reserved, normal, sign}, exponent if normal
  task automatic cls(input logic [3:0] zrns, input logic [11:0] te);
    chk(64'({clsZero, clsReserved, clsNormal, clsSign}), 64'(zrns));
    if (zrns[1]) begin
      chk(64'(clsTrueExp), 64'(te));
    end
  endtask

  // quiet cycle: every pulse must have dropped
  task automatic idle();
    reqGo = 1'b0;
    @(posedge clk_sys);
    #1;
    chk(64'({resValid, resWrite, trapReq}), 64'h0);
  endtask

  task automatic testReset();
    chk(64'({resValid, resWrite, trapReq, trapTypeCode}), 64'h0);
    chk(resWord, 64'h0);
  endtask

  task automatic testNormals();
    doOp(3'h1, 1'b0, 2'h0, 32'h0, 64'h3fc00000, 5'h10, 64'hbfc00000);
    cls(4'h2, 12'h000);
    chk(64'(clsSignif), 64'h0018_0000_0000_0000);
    doOp(3'h1, 1'b0, 2'h0, 32'h0, 64'h3f400000, 5'h10, 64'hbf400000);
    cls(4'h2, 12'hfff);
    doOp(3'h1, 1'b0, 2'h0, 32'h0, 64'h00800000, 5'h10, 64'h80800000);
    cls(4'h2, 12'hf82);
    doOp(3'h1, 1'b0, 2'h0, 32'h0, 64'h7f7fffff, 5'h10, 64'hff7fffff);
    cls(4'h2, 12'h07f);
    doOp(3'h0, 1'b1, 2'h0, 32'h0, 64'h3ff8_0000_0000_0000, 5'h10,
         64'h3ff8_0000_0000_0000);
    chk(64'(clsSignif), 64'h0018_0000_0000_0000);
    reqImm = 1'b1;
    doOp(3'h1, 1'b1, 2'h0, 32'h0, 64'h4008_0000_0000_0000, 5'h10,
         64'hc008_0000_0000_0000);
    cls(4'h2, 12'h001);
    reqImm = 1'b0;
    doOp(3'h1, 1'b1, 2'h0, 32'h0, 64'hbff8_0000_0000_0000, 5'h10,
         64'h3ff8_0000_0000_0000);
    cls(4'h3, 12'h000);
    idle();
  endtask

  task automatic testZeroReserved();
    doOp(3'h1, 1'b0, 2'h0, 32'h0, 64'h80000000, 5'h10, 64'h0);
    cls(4'h9, 12'h0);
    doOp(3'h0, 1'b1, 2'h0, 32'h0, 64'h0, 5'h10, 64'h0);
    cls(4'h8, 12'h0);
    doOp(3'h1, 1'b0, 2'h0, 32'h0, 64'h7f800000, 5'h0d, 64'h0);
    cls(4'h4, 12'h0);
    doOp(3'h4, 1'b1, 2'h0, 32'h1, 64'h7ff8_0000_0000_0000, 5'h0d,
         64'h0);
    cls(4'h4, 12'h0);
    doOp(3'h3, 1'b0, 2'h2, 32'h0, 64'h00000001, 5'h0d, 64'h0);
    cls(4'h4, 12'h0);
    doOp(3'h0, 1'b1, 2'h0, 32'h0, 64'hfff0_0000_0000_0000, 5'h10,
         64'hfff0_0000_0000_0000);
    cls(4'h5, 12'h0);
    idle();
  endtask

  task automatic testScale();
    doOp(3'h4, 1'b0, 2'h0, 32'h2, 64'h3fc00000, 5'h10, 64'h40c00000);
    doOp(3'h4, 1'b0, 2'h0, 32'h1, 64'h7f000000, 5'h0a, 64'h0);
    reqUte = 1'b0;
    doOp(3'h4, 1'b0, 2'h0, 32'hffffff38, 64'h3fc00000, 5'h11,
         64'h0);
    reqUte = 1'b1;
    doOp(3'h4, 1'b0, 2'h0, 32'hffffff38, 64'h3fc00000, 5'h09,
         64'h0);
    reqUte = 1'b0;
    idle();
  endtask

  task automatic testConvert();
    doOp(3'h2, 1'b0, 2'h0, 32'h0, 64'h123456ff, 5'h10, 64'hbf800000);
    doOp(3'h2, 1'b0, 2'h1, 32'h0, 64'h00008000, 5'h10, 64'hc7000000);
    doOp(3'h2, 1'b0, 2'h2, 32'h0, 64'h00000005, 5'h10, 64'h40a00000);
    doOp(3'h2, 1'b1, 2'h3, 32'h0, 64'hffffffff, 5'h10,
         64'hbff0_0000_0000_0000);
    doOp(3'h2, 1'b0, 2'h2, 32'h0, 64'h01000001, 5'h16, 64'h4b800000);
    doOp(3'h3, 1'b0, 2'h2, 32'h0, 64'h3fc00000, 5'h16, 64'h1);
    doOp(3'h3, 1'b0, 2'h0, 32'h0, 64'h43000000, 5'h0a, 64'h0);
    doOp(3'h3, 1'b0, 2'h0, 32'h0, 64'hc3000000, 5'h10, 64'hffffff80);
    doOp(3'h3, 1'b1, 2'h1, 32'h0, 64'hc008_0000_0000_0000, 5'h10,
         64'hfffffffd);
    idle();
  endtask

  task automatic testIllegal();
    for (int c = 5; c < 8; c++) begin
      doOp(3'(c), 1'b0, 2'h0, 32'h0, 64'h3fc00000, 5'h0c, 64'h0);
    end
    idle();
  endtask

  // cut a hang short well beyond the forty or so cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    reqGo = 1'b0;
    reqImm = 1'b0;
    reqDouble = 1'b0;
    reqUte = 1'b0;
    reqCode = 3'h0;
    reqLen = 2'h0;
    reqScale = 32'h0;
    reqBytes = 64'h0;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    @(posedge clk_sys);
    #1;
    testReset();
    testNormals();
    testZeroReserved();
    testScale();
    testConvert();
    testIllegal();
    final_report();
  end
endmodule
`default_nettype wire
